// >>> flow_alarm_unit_scaler.sv
// Flow alarm evaluation and unit / conversion factor settings with APB access
`timescale 1ns/1ps
`include "flow_alarm_map.svh"

module flow_alarm_unit_scaler #(
  parameter int FLOW_W = 10,
  parameter int TICK_CYC = `FA_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic low_status,
  output logic high_status,
  output logic [1:0] iso_out,
  output logic factor_active
);
  import flow_alarm_pkg::*;

  // Thresholds are ten bits wide, so a narrower flow word could not hold them
  if (FLOW_W < 10 || FLOW_W > 16 || TICK_CYC < 1) begin : g_param_check
    $error("flow_alarm_unit_scaler: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic enable_reg;
  logic ctlr_reg;
  logic [1:0] latch_reg;
  out_assign_e out_sel_reg [2];
  logic [9:0] low_thr_reg;
  logic [9:0] high_thr_reg;
  logic [11:0] delay_reg [2];
  logic [5:0] unit_reg;
  kfactor_s kf_reg;
  custom_unit_s cu_reg;
  logic [FLOW_W-1:0] flow_reg;
  logic [FLOW_W-1:0] sp_reg;
  apb_req_s req;
  logic wr_acc;
  logic rd_acc;
  logic mapped;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign wr_acc = req.sel && req.enable && req.write;
  assign rd_acc = req.sel && !req.enable && !req.write;

  // Address decode; every register answers with zero wait states
  always_comb begin
    unique case (req.addr)
      `FA_CTRL_OFS, `FA_LOW_OFS, `FA_HIGH_OFS, `FA_DELAY_OFS, `FA_UNIT_OFS,
      `FA_KF_OFS, `FA_CUNIT_OFS, `FA_FLOW_OFS, `FA_SP_OFS, `FA_STAT_OFS,
      `FA_SCALE_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Control register; out-of-range writes keep the old field value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= 1'b0;
      ctlr_reg <= 1'b0;
      latch_reg <= 2'b00;
      out_sel_reg[0] <= out_none;
      out_sel_reg[1] <= out_none;
    end else if (wr_acc && req.addr == `FA_CTRL_OFS) begin
      enable_reg <= req.wdata[`FA_CTRL_EN_BIT];
      ctlr_reg <= req.wdata[`FA_CTRL_CTLR_BIT];
      latch_reg <= {req.wdata[`FA_CTRL_LATCH_HI_BIT], req.wdata[`FA_CTRL_LATCH_LO_BIT]};
      if (req.wdata[`FA_CTRL_OUT0_LSB +: 2] != 2'h3) begin
        out_sel_reg[0] <= out_assign_e'(req.wdata[`FA_CTRL_OUT0_LSB +: 2]);
      end
      if (req.wdata[`FA_CTRL_OUT1_LSB +: 2] != 2'h3) begin
        out_sel_reg[1] <= out_assign_e'(req.wdata[`FA_CTRL_OUT1_LSB +: 2]);
      end
    end
  end

  // Thresholds in tenths of a percent of full scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_thr_reg <= 10'd0;
      high_thr_reg <= `FA_THR_MAX;
    end else if (wr_acc) begin
      if (req.addr == `FA_LOW_OFS && req.wdata[9:0] <= `FA_THR_MAX) begin
        low_thr_reg <= req.wdata[9:0];
      end
      if (req.addr == `FA_HIGH_OFS && req.wdata[9:0] <= `FA_THR_MAX) begin
        high_thr_reg <= req.wdata[9:0];
      end
    end
  end

  // Delays: low in bits 11:0, high in bits 27:16
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_reg[0] <= 12'd0;
      delay_reg[1] <= 12'd0;
    end else if (wr_acc && req.addr == `FA_DELAY_OFS) begin
      if (req.wdata[11:0] <= `FA_DELAY_MAX) begin
        delay_reg[0] <= req.wdata[11:0];
      end
      if (req.wdata[27:16] <= `FA_DELAY_MAX) begin
        delay_reg[1] <= req.wdata[27:16];
      end
    end
  end

  // Unit, conversion factor and custom unit settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_reg <= `FA_UNIT_RST;
      kf_reg <= '{mode: kf_off, index: `FA_KF_IDX_RST, user: `FA_KF_USER_RST};
      cu_reg <= '{volume: `FA_CU_VOL_RST, base: tb_min, use_density: 1'b0};
    end else if (wr_acc) begin
      if (req.addr == `FA_UNIT_OFS && req.wdata[5:0] != 6'd0
          && req.wdata[5:0] <= `FA_UNIT_MAX) begin
        unit_reg <= req.wdata[5:0];
      end
      if (req.addr == `FA_KF_OFS) begin
        if (req.wdata[`FA_KF_MODE_LSB +: 2] != 2'h3) begin
          kf_reg.mode <= kf_mode_e'(req.wdata[`FA_KF_MODE_LSB +: 2]);
        end
        if (req.wdata[`FA_KF_IDX_LSB +: 5] != 5'd0
            && req.wdata[`FA_KF_IDX_LSB +: 5] <= `FA_KF_IDX_MAX) begin
          kf_reg.index <= req.wdata[`FA_KF_IDX_LSB +: 5];
        end
        if (req.wdata[`FA_KF_USER_LSB +: 20] >= `FA_KF_USER_MIN
            && req.wdata[`FA_KF_USER_LSB +: 20] <= `FA_KF_USER_MAX) begin
          kf_reg.user <= req.wdata[`FA_KF_USER_LSB +: 20];
        end
      end
      if (req.addr == `FA_CUNIT_OFS) begin
        cu_reg.volume <= req.wdata[`FA_CU_VOL_LSB +: 20];
        cu_reg.base <= time_base_e'(req.wdata[`FA_CU_TB_LSB +: 2]);
        cu_reg.use_density <= req.wdata[`FA_CU_DENS_BIT];
      end
    end
  end

  // Measured flow from the front end and set point, both written over the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_reg <= '0;
      sp_reg <= '0;
    end else if (wr_acc) begin
      if (req.addr == `FA_FLOW_OFS) begin
        flow_reg <= req.wdata[FLOW_W-1:0];
      end
      if (req.addr == `FA_SP_OFS) begin
        sp_reg <= req.wdata[FLOW_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm conditions
  // ----------------------------------------------------------------
  logic [FLOW_W-1:0] dev;
  logic [1:0] raw;
  logic [FLOW_W-1:0] low_w;
  logic [FLOW_W-1:0] high_w;

  assign low_w = FLOW_W'(low_thr_reg);
  assign high_w = FLOW_W'(high_thr_reg);
  assign dev = (sp_reg >= flow_reg) ? sp_reg - flow_reg : flow_reg - sp_reg;

  // Raw conditions; thresholds share the flow scale of 0.1% per count
  always_comb begin
    if (!enable_reg) begin
      raw = 2'b00;
    end else if (ctlr_reg) begin
      raw[0] = (dev >= low_w) && (flow_reg < sp_reg);
      raw[1] = (dev >= high_w) && (flow_reg > sp_reg);
    end else begin
      raw[0] = flow_reg < low_w;
      raw[1] = flow_reg > high_w;
    end
  end

  // ----------------------------------------------------------------
  // Seconds tick and persistence timers
  // ----------------------------------------------------------------
  logic [31:0] div_reg;
  logic tick;

  // One-second enable from the clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 32'd0;
    end else if (div_reg == 32'(TICK_CYC - 1)) begin
      div_reg <= 32'd0;
    end else begin
      div_reg <= div_reg + 32'd1;
    end
  end
  assign tick = (div_reg == 32'(TICK_CYC - 1));

  alarm_state_e st_reg [2];
  logic [11:0] sec_reg [2];
  logic [1:0] valid;
  logic [1:0] out_latch_reg;

  // Per-alarm qualifier: idle, waiting out the delay, validated
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_reg[i] <= al_idle;
        sec_reg[i] <= 12'd0;
      end else begin
        unique case (st_reg[i])
          al_idle: begin
            sec_reg[i] <= 12'd0;
            if (raw[i]) begin
              st_reg[i] <= (delay_reg[i] == 12'd0) ? al_valid : al_wait;
            end
          end
          al_wait: begin
            if (!raw[i]) begin
              st_reg[i] <= al_idle;
            end else if (tick) begin
              sec_reg[i] <= sec_reg[i] + 12'd1;
              if (sec_reg[i] + 12'd1 >= delay_reg[i]) begin
                st_reg[i] <= al_valid;
              end
            end
          end
          al_valid: begin
            if (!raw[i]) begin
              st_reg[i] <= al_idle;
            end
          end
          default: st_reg[i] <= al_idle;
        endcase
      end
    end
    assign valid[i] = (st_reg[i] == al_valid) && raw[i];

    // Latch holds until alarm disable or latch clear, never on the flow returning
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_latch_reg[i] <= 1'b0;
      end else if (!enable_reg || !latch_reg[i]) begin
        out_latch_reg[i] <= 1'b0;
      end else if (valid[i]) begin
        out_latch_reg[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [1:0] drive;
  assign drive = valid | out_latch_reg;

  // Status markers and isolated outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_status <= 1'b0;
      high_status <= 1'b0;
      iso_out <= 2'b00;
      factor_active <= 1'b0;
    end else begin
      low_status <= valid[0];
      high_status <= valid[1];
      for (int k = 0; k < 2; k++) begin
        iso_out[k] <= (out_sel_reg[k] == out_low) ? drive[0] :
                      (out_sel_reg[k] == out_high) ? drive[1] : 1'b0;
      end
      factor_active <= (kf_reg.mode != kf_off) && (unit_reg != `FA_UNIT_PCT);
    end
  end

  // Effective scale: user factor in thousandths, the raw table index in table mode, or unity (1000) when bypassed
  logic [19:0] scale;
  assign scale = (unit_reg == `FA_UNIT_PCT || kf_reg.mode == kf_off) ? 20'd1000 :
                 (kf_reg.mode == kf_user) ? kf_reg.user : 20'(kf_reg.index);

  // ----------------------------------------------------------------
  // APB read path and answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= req.sel && !req.enable;
      pslverr <= req.sel && !req.enable && !mapped;
      if (rd_acc) begin
        unique case (req.addr)
          `FA_CTRL_OFS: prdata <= {24'h0, 2'(out_sel_reg[1]), 2'(out_sel_reg[0]),
                                   latch_reg, ctlr_reg, enable_reg};
          `FA_LOW_OFS: prdata <= {22'h0, low_thr_reg};
          `FA_HIGH_OFS: prdata <= {22'h0, high_thr_reg};
          `FA_DELAY_OFS: prdata <= {4'h0, delay_reg[1], 4'h0, delay_reg[0]};
          `FA_UNIT_OFS: prdata <= {26'h0, unit_reg};
          `FA_KF_OFS: prdata <= {4'h0, kf_reg.user, 1'b0, kf_reg.index, 2'(kf_reg.mode)};
          `FA_CUNIT_OFS: prdata <= {9'h0, cu_reg.use_density, 2'(cu_reg.base), cu_reg.volume};
          `FA_FLOW_OFS: prdata <= 32'(flow_reg);
          `FA_SP_OFS: prdata <= 32'(sp_reg);
          `FA_STAT_OFS: prdata <= {24'h0, out_latch_reg, valid, raw,
                                   unit_reg == `FA_UNIT_MAX, factor_active};
          `FA_SCALE_OFS: prdata <= {12'h0, scale};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_disable_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_reg |-> ##1 (!low_status && !high_status)) else $error("alarm while disabled");
  a_low_thr_range: assert property (@(posedge pclk) disable iff (!presetn)
    low_thr_reg <= `FA_THR_MAX) else $error("low threshold out of range");
  a_high_thr_range: assert property (@(posedge pclk) disable iff (!presetn)
    high_thr_reg <= `FA_THR_MAX) else $error("high threshold out of range");
  a_meter_low: assert property (@(posedge pclk) disable iff (!presetn)
    (enable_reg && !ctlr_reg) |-> (raw[0] == (flow_reg < low_w))) else $error("meter low");
  a_ctlr_low: assert property (@(posedge pclk) disable iff (!presetn)
    (raw[0] && ctlr_reg) |-> (flow_reg < sp_reg && dev >= low_w)) else $error("ctlr low");
  a_meter_high: assert property (@(posedge pclk) disable iff (!presetn)
    (enable_reg && !ctlr_reg) |-> (raw[1] == (flow_reg > high_w))) else $error("meter high");
  a_ctlr_high: assert property (@(posedge pclk) disable iff (!presetn)
    (raw[1] && ctlr_reg) |-> (flow_reg > sp_reg && dev >= high_w)) else $error("ctlr high");
  a_zero_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg[0] == al_idle && raw[0] && delay_reg[0] == 12'd0) |=> st_reg[0] == al_valid)
    else $error("zero delay not immediate");
  a_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg[0] == al_wait && !raw[0]) |=> (st_reg[0] == al_idle) ##1 sec_reg[0] == 12'd0)
    else $error("timer not restarted");
  a_low_marker: assert property (@(posedge pclk) disable iff (!presetn)
    valid[0] |=> low_status) else $error("low marker missing");
  a_follow_out: assert property (@(posedge pclk) disable iff (!presetn)
    (out_sel_reg[0] == out_low && $past(out_sel_reg[0]) == out_low && !latch_reg[0]
     && !$past(out_latch_reg[0])) |-> iso_out[0] == $past(valid[0]))
    else $error("output not following");
  a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (out_latch_reg[0] && enable_reg && latch_reg[0]) |=> out_latch_reg[0])
    else $error("latch dropped");
  a_factor_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    unit_reg == `FA_UNIT_PCT |=> !factor_active) else $error("factor on percent unit");

  c_low_valid: cover property (@(posedge pclk) disable iff (!presetn) $rose(low_status));
  c_high_valid: cover property (@(posedge pclk) disable iff (!presetn) $rose(high_status));
  c_wait_abort: cover property (@(posedge pclk) disable iff (!presetn)
    st_reg[0] == al_wait ##1 st_reg[0] == al_idle);
  c_latched: cover property (@(posedge pclk) disable iff (!presetn)
    out_latch_reg[0] && !valid[0]);

endmodule // flow_alarm_unit_scaler

// >>> flow_alarm_map.svh
// Offsets, field positions, reset values and timing counts of the flow alarm block
`ifndef FLOW_ALARM_MAP_SVH
`define FLOW_ALARM_MAP_SVH

// Register byte offsets
`define FA_CTRL_OFS 12'h000
`define FA_LOW_OFS 12'h004
`define FA_HIGH_OFS 12'h008
`define FA_DELAY_OFS 12'h00c
`define FA_UNIT_OFS 12'h010
`define FA_KF_OFS 12'h014
`define FA_CUNIT_OFS 12'h018
`define FA_FLOW_OFS 12'h01c
`define FA_SP_OFS 12'h020
`define FA_STAT_OFS 12'h024
`define FA_SCALE_OFS 12'h028

// Control register fields
`define FA_CTRL_EN_BIT 0
`define FA_CTRL_CTLR_BIT 1
`define FA_CTRL_LATCH_LO_BIT 2
`define FA_CTRL_LATCH_HI_BIT 3
`define FA_CTRL_OUT0_LSB 4
`define FA_CTRL_OUT1_LSB 6

// Conversion factor register fields
`define FA_KF_MODE_LSB 0
`define FA_KF_IDX_LSB 2
`define FA_KF_USER_LSB 8

// Custom unit register fields
`define FA_CU_VOL_LSB 0
`define FA_CU_TB_LSB 20
`define FA_CU_DENS_BIT 22

// Reset values, range limits and the percent unit code
`define FA_UNIT_RST 6'd1
`define FA_KF_IDX_RST 5'd1
`define FA_KF_USER_RST 20'd1000
`define FA_CU_VOL_RST 20'd100
`define FA_THR_MAX 10'd1000
`define FA_DELAY_MAX 12'd3600
`define FA_UNIT_MAX 6'd47
`define FA_UNIT_PCT 6'd1
`define FA_KF_IDX_MAX 5'd22
`define FA_KF_USER_MIN 20'd1
`define FA_KF_USER_MAX 20'd999900

// Time base constants
`define FA_TICK_NS 1000000000
`define FA_CLK_NS 4
`define FA_TICK_CYC (`FA_TICK_NS / `FA_CLK_NS)

`endif

// >>> flow_alarm_pkg.sv
// Types shared by the flow alarm block
package flow_alarm_pkg;
  typedef enum logic [1:0] {
    kf_off = 2'h0,
    kf_table = 2'h1,
    kf_user = 2'h2
  } kf_mode_e;

  typedef enum logic [1:0] {
    tb_sec = 2'h0,
    tb_min = 2'h1,
    tb_hour = 2'h2,
    tb_day = 2'h3
  } time_base_e;

  typedef enum logic [1:0] {
    out_none = 2'h0,
    out_low = 2'h1,
    out_high = 2'h2
  } out_assign_e;

  typedef enum logic [2:0] {
    al_idle = 3'b001,
    al_wait = 3'b010,
    al_valid = 3'b100
  } alarm_state_e;

  // APB request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_s;

  // Gas conversion factor settings
  typedef struct packed {
    kf_mode_e mode;
    logic [4:0] index;
    logic [19:0] user;
  } kfactor_s;

  // Custom unit settings
  typedef struct packed {
    logic [19:0] volume;
    time_base_e base;
    logic use_density;
  } custom_unit_s;
endpackage

// >>> flow_front_end_model.sv
// Model of the analog measurement chain feeding flow codes
`timescale 1ns/1ps

module flow_front_end_model #(
  parameter int FLOW_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [FLOW_W-1:0] target,
  output logic [FLOW_W-1:0] flow_code,
  output logic settled
);
  // ----------------------------------------
  // Conversion output
  // ----------------------------------------
  // Slow mode slews one count per clock, like a lagging transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_code <= '0;
    end else if (!slow || flow_code == target) begin
      flow_code <= target;
    end else if (flow_code < target) begin
      flow_code <= flow_code + 1'b1;
    end else begin
      flow_code <= flow_code - 1'b1;
    end
  end

  // Reading only trusted once the slew has finished
  assign settled = (flow_code == target);
endmodule // flow_front_end_model

// >>> tb_flow_alarm_unit_scaler.sv
// Testbench for the flow alarm and unit scaling block
`timescale 1ns/1ps
`include "flow_alarm_map.svh"

module tb_flow_alarm_unit_scaler;
  import flow_alarm_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, low_status, high_status, factor_active, settled, err, ok;
  logic [1:0] iso_out;
  logic [9:0] target = '0, flow_code;
  int err_total = 0, num_checks = 0, n, m;

  // 250 MHz clock
  always #2 pclk = ~pclk;

  // Short second keeps delay scenarios brief
  flow_alarm_unit_scaler #(.FLOW_W(10), .TICK_CYC(10)) u_flow_alarm_unit_scaler (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_status(low_status), .high_status(high_status), .iso_out(iso_out),
    .factor_active(factor_active));

  flow_front_end_model #(.FLOW_W(10)) u_flow_front_end_model (
    .pclk(pclk), .presetn(presetn), .slow(slow), .target(target),
    .flow_code(flow_code), .settled(settled));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Flags packed as {iso_out, high_status, low_status}
  task automatic chk_flags(input logic [3:0] exp);
    chk_word({28'h0, iso_out, high_status, low_status}, {28'h0, exp});
  endtask

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask

  // Let the front end settle, hand its code over, wait out the status latency
  task automatic set_flow(input logic [9:0] v);
    @(posedge pclk);
    target <= v;
    m = 0;
    do begin
      @(posedge pclk);
      m++;
    end while (settled !== 1'b1 && m < 1000);
    if (m >= 1000) begin
      err_total++;
      complete_run();
    end
    apb(1'b1, `FA_FLOW_OFS, {22'h0, flow_code});
    repeat (3) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    chk_flags(4'h0);
    presetn <= 1'b1;
    rd_chk(`FA_CTRL_OFS, 32'h0);
    rd_chk(`FA_LOW_OFS, 32'h0);
    rd_chk(`FA_HIGH_OFS, 32'h3e8);
    rd_chk(`FA_DELAY_OFS, 32'h0);
    rd_chk(`FA_UNIT_OFS, 32'h1);
    rd_chk(`FA_KF_OFS, 32'h3e804);
    rd_chk(`FA_CUNIT_OFS, 32'h100064);
    rd_chk(12'h100, 32'h0);
    chk_word({31'h0, err}, 32'h1);
    // Thresholds; low kept below high by the configuring side
    apb(1'b1, `FA_LOW_OFS, 32'd200);
    apb(1'b1, `FA_HIGH_OFS, 32'd1001);
    rd_chk(`FA_HIGH_OFS, 32'h3e8);
    apb(1'b1, `FA_HIGH_OFS, 32'd800);
    // Disabled function raises nothing
    apb(1'b1, `FA_CTRL_OFS, 32'h90);
    set_flow(10'd100);
    chk_flags(4'h0);
    // Meter function, output 0 on low, output 1 on high
    apb(1'b1, `FA_CTRL_OFS, 32'h91);
    repeat (3) @(posedge pclk);
    chk_flags(4'h5);
    set_flow(10'd200);
    chk_flags(4'h0);
    slow <= 1'b1;
    set_flow(10'd801);
    chk_flags(4'ha);
    set_flow(10'd800);
    chk_flags(4'h0);
    slow <= 1'b0;
    // Latched low output, released by latch clear and by disable
    apb(1'b1, `FA_CTRL_OFS, 32'h95);
    set_flow(10'd100);
    set_flow(10'd500);
    chk_flags(4'h4);
    apb(1'b1, `FA_CTRL_OFS, 32'h91);
    repeat (3) @(posedge pclk);
    chk_flags(4'h0);
    apb(1'b1, `FA_CTRL_OFS, 32'h95);
    set_flow(10'd100);
    set_flow(10'd500);
    apb(1'b1, `FA_CTRL_OFS, 32'h94);
    repeat (3) @(posedge pclk);
    chk_flags(4'h0);
    // Controller function around a set point of 500
    apb(1'b1, `FA_SP_OFS, 32'd500);
    apb(1'b1, `FA_LOW_OFS, 32'd100);
    apb(1'b1, `FA_HIGH_OFS, 32'd100);
    apb(1'b1, `FA_CTRL_OFS, 32'h93);
    set_flow(10'd400);
    chk_flags(4'h5);
    set_flow(10'd401);
    chk_flags(4'h0);
    set_flow(10'd600);
    chk_flags(4'ha);
    set_flow(10'd599);
    chk_flags(4'h0);
    // Persistence delay, low only
    apb(1'b1, `FA_CTRL_OFS, 32'h91);
    apb(1'b1, `FA_LOW_OFS, 32'd200);
    apb(1'b1, `FA_HIGH_OFS, 32'd800);
    set_flow(10'd500);
    apb(1'b1, `FA_DELAY_OFS, 32'h0e110e10);
    rd_chk(`FA_DELAY_OFS, 32'h00000e10);
    apb(1'b1, `FA_DELAY_OFS, 32'h2);
    set_flow(10'd100);
    chk_flags(4'h0);
    m = 0;
    while (low_status !== 1'b1 && m < 40) begin
      @(posedge pclk);
      m++;
    end
    // Two ten-cycle seconds, the first one partial, plus two cycles of latency
    ok = (m >= 11 && m <= 20);
    chk_word({31'h0, ok}, 32'h1);
    set_flow(10'd900);
    chk_flags(4'ha);
    // Timer restarts when the condition drops early
    apb(1'b1, `FA_DELAY_OFS, 32'h3);
    set_flow(10'd500);
    set_flow(10'd100);
    // Exactly two seconds counted before the drop, so a stale timer would fire early
    repeat (12) @(posedge pclk);
    set_flow(10'd500);
    set_flow(10'd100);
    repeat (12) @(posedge pclk);
    chk_flags(4'h0);
    // Conversion factor and units
    apb(1'b1, `FA_KF_OFS, 32'h3e815);
    repeat (3) @(posedge pclk);
    chk_word({31'h0, factor_active}, 32'h0);
    apb(1'b1, `FA_UNIT_OFS, 32'd7);
    repeat (3) @(posedge pclk);
    chk_word({31'h0, factor_active}, 32'h1);
    rd_chk(`FA_SCALE_OFS, 32'd5);
    apb(1'b1, `FA_KF_OFS, 32'h3e803);
    rd_chk(`FA_KF_OFS, 32'h3e815);
    apb(1'b1, `FA_KF_OFS, 32'hf41dc16);
    rd_chk(`FA_SCALE_OFS, 32'hf41dc);
    apb(1'b1, `FA_KF_OFS, 32'hf41dc14);
    repeat (3) @(posedge pclk);
    chk_word({31'h0, factor_active}, 32'h0);
    apb(1'b1, `FA_UNIT_OFS, 32'd47);
    apb(1'b1, `FA_UNIT_OFS, 32'd48);
    rd_chk(`FA_UNIT_OFS, 32'd47);
    apb(1'b0, `FA_STAT_OFS, 32'h0);
    chk_word(rd & 32'h2, 32'h2);
    apb(1'b1, `FA_CUNIT_OFS, 32'h7fffff);
    rd_chk(`FA_CUNIT_OFS, 32'h7fffff);
    // Latched low output released by a reset in mid-run
    apb(1'b1, `FA_CTRL_OFS, 32'h95);
    repeat (3) @(posedge pclk);
    chk_flags(4'h5);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_flags(4'h0);
    presetn <= 1'b1;
    rd_chk(`FA_CTRL_OFS, 32'h0);
    chk_flags(4'h0);
    complete_run();
  end
endmodule // tb_flow_alarm_unit_scaler
